// file: common/slb_pkg.sv
// Purpose: Shared constants and types for the serial link self-test block.
// Assumes: System clock of 40 MHz; the link clock is the pixel clock.
// Notes: Register offsets are byte indices seen through the I2C pointer.
package slb_pkg;

  // ---------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------
  localparam int CLK_MHZ = 40;
  // Fast-mode data setup time before the stretched clock is released.
  localparam int SDA_SETUP_NS = 100;
  localparam int SETUP_CYC_I = (SDA_SETUP_NS * CLK_MHZ + 999) / 1000;
  localparam logic [3:0] SETUP_CYC = 4'(SETUP_CYC_I);

  // ---------------------------------------------------------------------
  // I2C addressing and register map
  // ---------------------------------------------------------------------
  localparam logic [6:0] LOCAL_ADDR = 7'h3a;
  localparam logic [6:0] REMOTE_ADDR = 7'h50;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_PASS = 8'h01;
  localparam logic [7:0] REG_GPIO = 8'h02;
  localparam logic [7:0] REG_ERRCNT = 8'h57;
  localparam int CTRL_SRC_BIT = 0;
  localparam int CTRL_CLK_LSB = 1;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic PASS_RST = 1'b0;
  localparam logic [3:0] GPIO_RST = 4'h0;
  localparam logic [7:0] ERR_MAX = 8'hff;

  // ---------------------------------------------------------------------
  // Test clock select codes
  // ---------------------------------------------------------------------
  localparam logic [1:0] CLKSEL_PIXEL = 2'h0;
  localparam logic [1:0] CLKSEL_RSVD = 2'h3;

  // Pin synchroniser idle value: bus lines idle high, straps low.
  localparam logic [4:0] PIN_SYNC_INIT = 5'h03;

  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_ACK, ST_WR, ST_RD, ST_MACK, ST_STRETCH, ST_REL
  } slb_i2c_st_t;

endpackage

// file: common/slb_link_if.sv
// Purpose: Carries the test run level and the errored-frame event between domains.
// Assumes: run is driven on clk, err_tgl on the link clock.
// Notes: Each side resynchronises what it receives.
`timescale 1ns/1ps
interface slb_link_if;
  logic run;
  logic err_tgl;
  modport ctrl (output run, input err_tgl);
  modport link (input run, output err_tgl);
endinterface

// file: rtl/slb_sync2.sv
// Purpose: Two flip-flop synchroniser for asynchronous levels.
// Assumes: Each bit is an independent level.
// Notes: The first stage is read only by the second.
`timescale 1ns/1ps
module slb_sync2 #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta;

  // Both stages reset to the idle value so no false edge appears.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      meta <= INIT;
      q <= INIT;
    end else begin
      meta <= d;
      q <= meta;
    end
  end

endmodule

// file: rtl/slb_link_check.sv
// Purpose: Checks the received test pattern frame by frame on the link clock.
// Assumes: Words count up from zero within each frame.
// Notes: The result pin pulse is shaped by the link clock itself.
`timescale 1ns/1ps
module slb_link_check (
  input wire logic link_clk,
  input wire logic rst_b,
  slb_link_if.link lnk,
  input wire logic link_locked,
  input wire logic link_word_valid,
  input wire logic [11:0] link_word,
  input wire logic link_frame_end,
  output logic result_pin
);

  logic link_rst_b;
  logic run_s;
  logic run_d;
  logic checking;
  logic done;
  logic [11:0] expect_word;
  logic frame_bad;
  logic bad_now;
  logic err_pulse;
  logic any_err;
  logic pass_lvl;

  // Reset and run level both enter this domain through two flops.
  slb_sync2 #(.W(1), .INIT(1'b0)) u_rst (
    .clk(link_clk), .rst_b(1'b1), .d(rst_b), .q(link_rst_b)
  );
  slb_sync2 #(.W(1), .INIT(1'b0)) u_run (
    .clk(link_clk), .rst_b(link_rst_b), .d(lnk.run), .q(run_s)
  );

  // Checking only while the run is on and the receiver holds lock.
  assign checking = run_s & link_locked; // R11 R12
  assign done = run_d & ~run_s;
  assign bad_now = frame_bad | (link_word_valid & (link_word != expect_word));

  // Pattern tracking within a frame; a lost lock also loses the word alignment.
  always_ff @(posedge link_clk) begin
    if (!link_rst_b || link_frame_end || !link_locked) begin
      expect_word <= 12'h000;
      frame_bad <= 1'b0;
    end else if (link_word_valid) begin
      expect_word <= expect_word + 12'h001;
      frame_bad <= bad_now & checking;
    end
  end

  // One event per errored frame; back-to-back frames give separate events.
  always_ff @(posedge link_clk) begin
    if (!link_rst_b) begin
      err_pulse <= 1'b0;
      lnk.err_tgl <= 1'b0;
      any_err <= 1'b0;
      run_d <= 1'b0;
    end else begin
      run_d <= run_s;
      err_pulse <= link_frame_end & checking & bad_now; // R5 R6
      if (link_frame_end && checking && bad_now) begin
        lnk.err_tgl <= ~lnk.err_tgl; // R8
      end
      if (link_frame_end && checking && bad_now) begin
        any_err <= 1'b1;
      end else if (run_s && !run_d) begin
        any_err <= 1'b0;
      end
    end
  end

  // High while checking, the outcome for one cycle at the end, else low.
  always_ff @(posedge link_clk) begin
    if (!link_rst_b) begin
      pass_lvl <= 1'b0;
    end else if (done) begin
      pass_lvl <= ~any_err; // R7
    end else begin
      pass_lvl <= checking; // R11
    end
  end

  // Low in the low half of the link clock; err_pulse never changes then, so no glitch.
  assign result_pin = pass_lvl & ~(err_pulse & ~link_clk); // R5 R6

  pulse_src_a: assert property (@(posedge link_clk) disable iff (!link_rst_b) // R5
    err_pulse |-> $past(link_frame_end) && $past(checking))
    else $error("error pulse without an errored frame end");
  result_once_a: assert property (@(posedge link_clk) disable iff (!link_rst_b) // R7
    done |=> (pass_lvl == !$past(any_err)) ##1 !pass_lvl)
    else $error("run outcome not shown for exactly one cycle");
  pass_high_a: assert property (@(posedge link_clk) disable iff (!link_rst_b) // R11
    $rose(checking) |=> pass_lvl)
    else $error("result pin not high once checking starts");

endmodule

// file: rtl/slb_bist_ctrl.sv
// Purpose: Self-test control of the serial link and its I2C control slave.
// Assumes: clk at 40 MHz; link_clk is the recovered pixel clock.
// Notes: Remote I2C transfers are bridged with clock stretching.
`timescale 1ns/1ps

// Behaviour
// R1: Test setup from receiver pins or register.
// R2: Enable pin high enters test, low leaves.
// R3: Pin select: pixel, oscillator fast, slow.
// R4: Register clock field; reserved code not used.
// R5: Half-period low pulse per errored frame.
// R6: Consecutive errored frames pulse separately.
// R7: Run outcome shown for one cycle.
// R8: Errored-frame count held until new session.
// R9: System supplies both clocks in oscillator mode.
// R10: Command transmitter pattern over back channel.
// R11: Lock in test: pin high, start checking.
// R12: Enable low stops checking.
// R13: Enable low returns link to normal.
// R14: I2C slave reaches registers and GPIO.
// R15: Bus lines open-drain, pull low only.
// R16: Fast-mode transfers up to 400 kbps.
// R17: Forward remote transfers only when pass-through.
// R18: Oscillator field sent to transmitter in test.
// R19: Stretch ninth clock while remote responds.
// R20: Reset clears test mode and count.
module slb_bist_ctrl (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic self_test_enable_pin,
  input wire logic test_clock_select_lo,
  input wire logic test_clock_select_hi,
  input wire logic remote_test_ack,
  input wire logic link_clk,
  input wire logic link_locked,
  input wire logic link_word_valid,
  input wire logic [11:0] link_word,
  input wire logic link_frame_end,
  output logic result_pin,
  output logic link_tx_test_cmd,
  output logic [1:0] link_tx_osc_field,
  output logic test_from_reg,
  output logic normal_mode,
  input wire logic scl_in,
  output logic scl_out,
  output logic scl_oe_b,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_b,
  output logic fwd_req,
  output logic fwd_read,
  output logic [7:0] fwd_byte,
  input wire logic fwd_done,
  input wire logic fwd_ack,
  input wire logic [7:0] fwd_rdata,
  output logic [3:0] gpio_out
);

  // -----------------------------------------------------------------------
  // Declarations
  // -----------------------------------------------------------------------
  slb_link_if lnk ();
  logic [4:0] pin_s;
  logic test_on;
  logic test_d;
  logic test_start;
  logic scl_s;
  logic sda_s;
  logic scl_d;
  logic sda_d;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic err_s;
  logic err_d;
  logic err_evt;
  logic [7:0] err_count;
  logic [7:0] ctrl;
  logic pass_en;
  logic [1:0] sel_field;
  slb_pkg::slb_i2c_st_t state;
  slb_pkg::slb_i2c_st_t next_st;
  logic [3:0] bit_cnt;
  logic [7:0] shreg;
  logic [7:0] rbuf;
  logic [7:0] ptr;
  logic ptr_set;
  logic rd_mode;
  logic remote;
  logic ack_ok;
  logic sda_drv;
  logic scl_hold;
  logic [3:0] setup_cnt;
  logic wr_en;
  logic [7:0] reg_rd;
  logic [7:0] rd_byte;

  // -----------------------------------------------------------------------
  // Pin synchronisers
  // -----------------------------------------------------------------------

  // Straps and bus lines are asynchronous, so each passes two flops.
  slb_sync2 #(.W(5), .INIT(slb_pkg::PIN_SYNC_INIT)) u_pins (
    .clk(clk),
    .rst_b(rst_b),
    .d({self_test_enable_pin, test_clock_select_hi, test_clock_select_lo, scl_in, sda_in}),
    .q(pin_s)
  );

  // The errored-frame toggle from the link domain is synchronised here.
  slb_sync2 #(.W(1), .INIT(1'b0)) u_err (
    .clk(clk),
    .rst_b(rst_b),
    .d(lnk.err_tgl),
    .q(err_s)
  );

  assign test_on = pin_s[4]; // R2
  assign scl_s = pin_s[1];
  assign sda_s = pin_s[0];

  // -----------------------------------------------------------------------
  // Test session control
  // -----------------------------------------------------------------------

  // Edge history for the session start, the link error events and the bus lines.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      test_d <= 1'b0;
      err_d <= 1'b0;
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      test_d <= test_on;
      err_d <= err_s;
      scl_d <= scl_s;
      sda_d <= sda_s;
    end
  end

  assign test_start = test_on & ~test_d;
  assign err_evt = err_s ^ err_d;

  // Register field overrides the pins only when software selects it.
  always_comb begin
    if (ctrl[slb_pkg::CTRL_SRC_BIT]) begin
      sel_field = ctrl[slb_pkg::CTRL_CLK_LSB +: 2]; // R1 R4
    end else begin
      sel_field = {test_clock_select_hi_s(pin_s), pin_s[2]}; // R1 R3
    end
    if (sel_field == slb_pkg::CLKSEL_RSVD) begin
      sel_field = slb_pkg::CLKSEL_PIXEL; // R4
    end
  end

  // Back-channel command and oscillator field follow the enable pin.
  // Checking waits for the transmitter to confirm it is in test as well.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      link_tx_test_cmd <= 1'b0; // R20
      link_tx_osc_field <= slb_pkg::CLKSEL_PIXEL;
      test_from_reg <= 1'b0;
      normal_mode <= 1'b1;
      lnk.run <= 1'b0;
    end else begin
      link_tx_test_cmd <= test_on; // R10
      link_tx_osc_field <= test_on ? sel_field : slb_pkg::CLKSEL_PIXEL; // R18 R9
      test_from_reg <= ctrl[slb_pkg::CTRL_SRC_BIT];
      normal_mode <= ~test_on; // R13
      lnk.run <= test_on & remote_test_ack; // R11 R12
    end
  end

  // Errored-frame count; a new session clears it, but an event in the
  // same cycle still counts.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      err_count <= 8'h00; // R20
    end else if (test_start) begin
      err_count <= err_evt ? 8'h01 : 8'h00; // R8
    end else if (err_evt && err_count != slb_pkg::ERR_MAX) begin
      err_count <= err_count + 8'h01; // R8
    end
  end

  // -----------------------------------------------------------------------
  // Link-side checker
  // -----------------------------------------------------------------------
  slb_link_check u_check (
    .link_clk(link_clk),
    .rst_b(rst_b),
    .lnk(lnk.link),
    .link_locked(link_locked),
    .link_word_valid(link_word_valid),
    .link_word(link_word),
    .link_frame_end(link_frame_end),
    .result_pin(result_pin)
  );

  // -----------------------------------------------------------------------
  // I2C slave
  // -----------------------------------------------------------------------

  // Start and stop are judged on the synchronised lines only.
  assign scl_rise = scl_s & ~scl_d;
  assign scl_fall = ~scl_s & scl_d;
  assign start_det = scl_s & scl_d & sda_d & ~sda_s;
  assign stop_det = scl_s & scl_d & ~sda_d & sda_s;

  // Lines are only ever pulled low; a high level is a release.
  assign scl_out = 1'b0; // R15
  assign sda_out = 1'b0; // R15
  assign scl_oe_b = ~scl_hold; // R15 R19
  assign sda_oe_b = ~sda_drv; // R15

  // Register read view.
  always_comb begin
    unique case (ptr)
      slb_pkg::REG_CTRL: reg_rd = ctrl;
      slb_pkg::REG_PASS: reg_rd = {7'h00, pass_en};
      slb_pkg::REG_GPIO: reg_rd = {4'h0, gpio_out};
      slb_pkg::REG_ERRCNT: reg_rd = err_count; // R8
      default: reg_rd = 8'h00;
    endcase
  end

  assign rd_byte = remote ? rbuf : reg_rd;
  assign wr_en = (state == slb_pkg::ST_WR) & scl_fall & (bit_cnt == 4'h8) & ~remote & ptr_set;

  // Writable registers steer the clock select, bridge and GPIO pins.
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ctrl <= slb_pkg::CTRL_RST;
      pass_en <= slb_pkg::PASS_RST;
      gpio_out <= slb_pkg::GPIO_RST;
    end else if (wr_en) begin
      if (ptr == slb_pkg::REG_CTRL) begin
        ctrl <= shreg; // R14
      end
      if (ptr == slb_pkg::REG_PASS) begin
        pass_en <= shreg[0]; // R17
      end
      if (ptr == slb_pkg::REG_GPIO) begin
        gpio_out <= shreg[3:0]; // R14
      end
    end
  end

  // Byte-level protocol engine. Bits are taken on SCL rise and driven
  // after SCL fall, which leaves nearly half a period of margin at 400 kbps.
  always_ff @(posedge clk) begin
    fwd_req <= 1'b0;
    if (!rst_b) begin
      state <= slb_pkg::ST_IDLE;
      next_st <= slb_pkg::ST_IDLE;
      bit_cnt <= 4'h0;
      shreg <= 8'h00;
      rbuf <= 8'h00;
      ptr <= 8'h00;
      ptr_set <= 1'b0;
      rd_mode <= 1'b0;
      remote <= 1'b0;
      ack_ok <= 1'b0;
      sda_drv <= 1'b0;
      scl_hold <= 1'b0;
      setup_cnt <= 4'h0;
      fwd_read <= 1'b0;
      fwd_byte <= 8'h00;
    end else if (stop_det) begin
      state <= slb_pkg::ST_IDLE;
      sda_drv <= 1'b0;
    end else if (start_det) begin
      state <= slb_pkg::ST_ADDR;
      bit_cnt <= 4'h0;
      ptr_set <= 1'b0;
      sda_drv <= 1'b0;
    end else begin
      unique case (state)
        slb_pkg::ST_IDLE: state <= slb_pkg::ST_IDLE;
        slb_pkg::ST_ADDR: begin
          if (scl_rise) begin
            shreg <= {shreg[6:0], sda_s};
            bit_cnt <= bit_cnt + 4'h1;
          end else if (scl_fall && bit_cnt == 4'h8) begin
            bit_cnt <= 4'h0;
            rd_mode <= shreg[0];
            if (shreg[7:1] == slb_pkg::LOCAL_ADDR) begin
              remote <= 1'b0; // R14
              sda_drv <= 1'b1;
              ack_ok <= 1'b1;
              state <= slb_pkg::ST_ACK;
            end else if (pass_en && shreg[7:1] == slb_pkg::REMOTE_ADDR) begin
              remote <= 1'b1; // R17
              fwd_req <= 1'b1;
              fwd_read <= shreg[0];
              fwd_byte <= shreg;
              scl_hold <= 1'b1; // R19
              next_st <= slb_pkg::ST_ACK;
              state <= slb_pkg::ST_STRETCH;
            end else begin
              state <= slb_pkg::ST_IDLE; // R17
            end
          end
        end
        slb_pkg::ST_ACK: begin
          if (scl_fall) begin
            bit_cnt <= 4'h0;
            sda_drv <= 1'b0;
            if (!ack_ok) begin
              state <= slb_pkg::ST_IDLE;
            end else if (rd_mode) begin
              shreg <= rd_byte;
              sda_drv <= ~rd_byte[7];
              ptr <= remote ? ptr : ptr + 8'h01;
              state <= slb_pkg::ST_RD;
            end else begin
              state <= slb_pkg::ST_WR;
            end
          end
        end
        slb_pkg::ST_WR: begin
          if (scl_rise) begin
            shreg <= {shreg[6:0], sda_s};
            bit_cnt <= bit_cnt + 4'h1;
          end else if (scl_fall && bit_cnt == 4'h8) begin
            bit_cnt <= 4'h0;
            if (remote) begin
              fwd_req <= 1'b1;
              fwd_read <= 1'b0;
              fwd_byte <= shreg;
              scl_hold <= 1'b1; // R19
              next_st <= slb_pkg::ST_ACK;
              state <= slb_pkg::ST_STRETCH;
            end else begin
              sda_drv <= 1'b1;
              ack_ok <= 1'b1;
              ptr <= ptr_set ? ptr + 8'h01 : shreg;
              ptr_set <= 1'b1;
              state <= slb_pkg::ST_ACK;
            end
          end
        end
        slb_pkg::ST_RD: begin
          if (scl_fall) begin
            if (bit_cnt == 4'h7) begin
              bit_cnt <= 4'h0;
              sda_drv <= 1'b0;
              state <= slb_pkg::ST_MACK;
            end else begin
              shreg <= {shreg[6:0], 1'b0};
              sda_drv <= ~shreg[6];
              bit_cnt <= bit_cnt + 4'h1;
            end
          end
        end
        slb_pkg::ST_MACK: begin
          if (scl_rise) begin
            ack_ok <= ~sda_s;
          end else if (scl_fall) begin
            if (!ack_ok) begin
              state <= slb_pkg::ST_IDLE;
            end else if (remote) begin
              fwd_req <= 1'b1;
              fwd_read <= 1'b1;
              fwd_byte <= 8'h00;
              scl_hold <= 1'b1; // R19
              next_st <= slb_pkg::ST_RD;
              state <= slb_pkg::ST_STRETCH;
            end else begin
              shreg <= reg_rd;
              sda_drv <= ~reg_rd[7];
              ptr <= ptr + 8'h01;
              state <= slb_pkg::ST_RD;
            end
          end
        end
        slb_pkg::ST_STRETCH: begin
          if (fwd_done) begin
            rbuf <= fwd_rdata;
            setup_cnt <= slb_pkg::SETUP_CYC;
            state <= slb_pkg::ST_REL;
            if (next_st == slb_pkg::ST_RD) begin
              shreg <= fwd_rdata;
              sda_drv <= ~fwd_rdata[7];
            end else begin
              ack_ok <= fwd_ack;
              sda_drv <= fwd_ack;
            end
          end
        end
        slb_pkg::ST_REL: begin
          // SDA settles before SCL is let go, to meet fast-mode setup.
          if (setup_cnt <= 4'h1) begin
            scl_hold <= 1'b0; // R16
            state <= next_st;
          end else begin
            setup_cnt <= setup_cnt - 4'h1;
          end
        end
      endcase
    end
  end

  // Picks the high clock-select strap out of the synchronised group.
  function automatic logic test_clock_select_hi_s(input logic [4:0] p);
    return p[3];
  endfunction

  // -----------------------------------------------------------------------
  // Assertions
  // -----------------------------------------------------------------------
  cmd_follow_a: assert property (@(posedge clk) disable iff (!rst_b) // R10
    $rose(test_on) |=> link_tx_test_cmd && !normal_mode)
    else $error("transmitter not commanded after enable rose");
  err_clear_a: assert property (@(posedge clk) disable iff (!rst_b) // R8
    test_start |=> err_count <= 8'h01)
    else $error("count not cleared at session start");
  err_hold_a: assert property (@(posedge clk) disable iff (!rst_b) // R8
    !test_start && !err_evt |=> $stable(err_count))
    else $error("count changed without an errored frame");
  stretch_hold_a: assert property (@(posedge clk) disable iff (!rst_b) // R19
    state == slb_pkg::ST_STRETCH |-> !scl_oe_b)
    else $error("clock not held while remote responds");
  no_fwd_a: assert property (@(posedge clk) disable iff (!rst_b) // R17
    fwd_req |-> pass_en && remote)
    else $error("transfer forwarded with pass-through off");
  setup_gap_a: assert property (@(posedge clk) disable iff (!rst_b) // R16
    state == slb_pkg::ST_STRETCH && fwd_done |=> scl_hold [*4] ##1 !scl_hold)
    else $error("clock released without data setup time");
  osc_field_a: assert property (@(posedge clk) disable iff (!rst_b) // R4
    link_tx_osc_field != slb_pkg::CLKSEL_RSVD)
    else $error("reserved clock code sent to transmitter");
  normal_back_a: assert property (@(posedge clk) disable iff (!rst_b) // R13
    $fell(test_on) |=> normal_mode && !link_tx_test_cmd ##1 !lnk.run)
    else $error("link not returned to normal after enable fell");
  reset_clear_a: assert property (@(posedge clk) // R20
    !rst_b |=> err_count == 8'h00 && !link_tx_test_cmd && scl_oe_b)
    else $error("reset left test state or count set");

endmodule

// file: tb/slb_far_model.sv
// Purpose: Far side: pattern source on the link clock and remote bus responder.
// Assumes: Frames of four counting words; bad corrupts word one of a frame.
// Notes: Idle words show the inverse of the last value so they never look valid.
`timescale 1ns/1ps
module slb_far_model (
  input wire logic clk,
  input wire logic link_clk,
  input wire logic send,
  input wire logic bad,
  output logic link_locked,
  output logic link_word_valid,
  output logic [11:0] link_word,
  output logic link_frame_end,
  input wire logic fwd_req,
  output logic fwd_done,
  output logic fwd_ack,
  output logic [7:0] fwd_rdata
);
  logic [2:0] idx = 3'h0;
  logic [5:0] wait_cnt = 6'h0;
  wire logic busy = idx < 3'h4 && (send || idx != 3'h0);
  initial begin
    {link_locked, link_word_valid, link_frame_end, fwd_done} = 4'h0;
    link_word = 12'h000;
    fwd_ack = 1'h1;
    fwd_rdata = 8'ha5;
  end
  // Frames start only when commanded and always run to their end; lock is kept.
  always @(negedge link_clk) begin
    link_locked <= link_locked | send;
    link_word_valid <= busy;
    link_word <= busy ? {9'h000, idx ^ {2'h0, bad && idx == 3'h1}} : ~link_word;
    link_frame_end <= idx == 3'h4;
    idx <= busy ? idx + 3'h1 : 3'h0;
  end
  // A slow remote outlasts the master's low phase, so the bridge must stretch.
  always @(posedge clk) begin
    fwd_done <= wait_cnt == 6'h01;
    wait_cnt <= fwd_req ? 6'h3f : (wait_cnt != 6'h0 ? wait_cnt - 6'h01 : 6'h0);
  end
endmodule

// file: tb/test_slb_bist_ctrl.sv
// Purpose: Self-checking bench for the link self-test and bus control block.
// Assumes: The far side model supplies frames and remote answers.
// Notes: Bus lines are resolved here as wired-and with pull-ups.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin err_total++; \
  $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
module test_slb_bist_ctrl;
  logic clk = 1'h0, link_clk = 1'h0, rst_b = 1'h0, en = 1'h0, sel_lo = 1'h0, sel_hi = 1'h0;
  logic ack_in = 1'h0, bad = 1'h0, scl_m = 1'h1, sda_m = 1'h1, stretch = 1'h0, n;
  logic result_pin, cmd, from_reg, normal, scl_oe_b, sda_oe_b, fwd_req, fwd_done, fwd_ack;
  logic locked, wv, fe;
  logic [1:0] osc;
  logic [3:0] gpio;
  logic [7:0] fwd_rdata, q;
  logic [11:0] word;
  logic [15:0] seed = 16'h199e;
  int err_total = 0, comparisons = 0, pulses = 0, fwds = 0, c;
  wire logic scl_w = scl_m & scl_oe_b;
  wire logic sda_w = sda_m & sda_oe_b;
  always #12.5 clk = ~clk;
  // The pixel clock runs all the time, offset in phase from the system clock.
  initial #7 forever #40 link_clk = ~link_clk;
  // Result pulses and forwarded requests are tallied as they occur; a stretched clock is flagged.
  always @(negedge result_pin) pulses++;
  always @(negedge clk) if (fwd_req === 1'h1) fwds++;
  always @(negedge clk) if (scl_m && scl_w !== 1'h1) stretch = 1'h1;
  slb_bist_ctrl u_slb_bist_ctrl (.clk(clk), .rst_b(rst_b), .self_test_enable_pin(en),
    .test_clock_select_lo(sel_lo), .test_clock_select_hi(sel_hi), .remote_test_ack(ack_in),
    .link_clk(link_clk), .link_locked(locked), .link_word_valid(wv), .link_word(word),
    .link_frame_end(fe), .result_pin(result_pin), .link_tx_test_cmd(cmd),
    .link_tx_osc_field(osc), .test_from_reg(from_reg), .normal_mode(normal),
    .scl_in(scl_w), .scl_out(), .scl_oe_b(scl_oe_b), .sda_in(sda_w), .sda_out(),
    .sda_oe_b(sda_oe_b), .fwd_req(fwd_req), .fwd_read(), .fwd_byte(), .fwd_done(fwd_done),
    .fwd_ack(fwd_ack), .fwd_rdata(fwd_rdata), .gpio_out(gpio));
  slb_far_model u_slb_far_model (.clk(clk), .link_clk(link_clk), .send(cmd), .bad(bad),
    .link_locked(locked), .link_word_valid(wv), .link_word(word),
    .link_frame_end(fe), .fwd_req(fwd_req), .fwd_done(fwd_done), .fwd_ack(fwd_ack),
    .fwd_rdata(fwd_rdata));
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic wt(input int k);
    repeat (k) @(negedge clk);
  endtask
  // One bit per 100 cycles keeps the bus at 400 kbps; a stretched clock is waited out.
  task automatic i2c_bit(input logic b, output logic r);
    int i;
    wt(10);
    sda_m = b;
    wt(40);
    scl_m = 1'h1;
    for (i = 0; i < 600 && scl_w !== 1'h1; i++) @(negedge clk);
    wt(50);
    r = sda_w;
    scl_m = 1'h0;
  endtask
  task automatic i2c_byte(input logic [7:0] d, input logic m, output logic [7:0] r,
      output logic nak);
    int k;
    for (k = 7; k >= 0; k--) i2c_bit(d[k], r[k]);
    i2c_bit(m, nak);
  endtask
  task automatic i2c_start();
    wt(10);
    sda_m = 1'h1;
    wt(40);
    scl_m = 1'h1;
    wt(50);
    sda_m = 1'h0;
    wt(50);
    scl_m = 1'h0;
  endtask
  task automatic i2c_stop();
    wt(10);
    sda_m = 1'h0;
    wt(40);
    scl_m = 1'h1;
    wt(50);
    sda_m = 1'h1;
    wt(50);
  endtask
  task automatic reg_wr(input logic [7:0] p, input logic [7:0] v);
    i2c_start();
    i2c_byte({slb_pkg::LOCAL_ADDR, 1'h0}, 1'h1, q, n);
    i2c_byte(p, 1'h1, q, n);
    i2c_byte(v, 1'h1, q, n);
    i2c_stop();
  endtask
  task automatic reg_rd(input logic [7:0] p, output logic [7:0] v);
    i2c_start();
    i2c_byte({slb_pkg::LOCAL_ADDR, 1'h0}, 1'h1, q, n);
    i2c_byte(p, 1'h1, q, n);
    i2c_start();
    i2c_byte({slb_pkg::LOCAL_ADDR, 1'h1}, 1'h1, q, n);
    i2c_byte(8'hff, 1'h1, v, n);
    i2c_stop();
  endtask
  task automatic remote(input logic exp_nak, input int exp_fwd);
    i2c_start();
    i2c_byte({slb_pkg::REMOTE_ADDR, 1'h0}, 1'h1, q, n);
    i2c_stop();
    `CHK("remote nack", exp_nak, n)
    `CHK("forwards", exp_fwd, fwds)
  endtask
  // A session with nerr consecutive errored frames, then the end of test.
  task automatic session(input int nerr);
    int i;
    en = 1'h1;
    ack_in = 1'h1;
    for (i = 0; i < 200 && result_pin !== 1'h1; i++) @(negedge clk);
    `CHK("pin high", 1'h1, result_pin)
    @(posedge fe);
    pulses = 0;
    bad = 1'h1;
    repeat (nerr) @(posedge fe);
    bad = 1'h0;
    repeat (3) @(posedge fe);
    `CHK("pulses", nerr, pulses)
    reg_rd(slb_pkg::REG_ERRCNT, q);
    `CHK("count", 8'(nerr), q)
    en = 1'h0;
    ack_in = 1'h0;
    wt(40);
    `CHK("end pin", 2'h1, {result_pin, normal})
    `CHK("end fall", nerr + 1, pulses)
    reg_rd(slb_pkg::REG_ERRCNT, q);
    `CHK("count held", 8'(nerr), q)
    $display("test session %0d done", nerr);
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // The watchdog allows well beyond the expected 53000 cycles.
  initial begin
    wt(95000);
    err_total++;
    report_and_stop();
  end
  initial begin
    wt(8);
    rst_b = 1'h1;
    wt(4);
    `CHK("reset", 6'h30, {normal, scl_oe_b, cmd, result_pin, osc})
    seed = lfsr(seed);
    reg_wr(slb_pkg::REG_GPIO, {4'h0, seed[3:0]});
    `CHK("gpio", seed[3:0], gpio)
    reg_rd(8'h33, q);
    `CHK("unmapped", 8'h00, q)
    remote(1'h1, 0);
    reg_wr(slb_pkg::REG_PASS, 8'h01);
    remote(1'h0, 1);
    `CHK("stretch", 1'h1, stretch)
    $display("test bus done");
    for (c = 0; c < 8; c++) begin
      reg_wr(slb_pkg::REG_CTRL, {5'h00, c[1:0], c[2]});
      {sel_hi, sel_lo} = c[2] ? ~c[1:0] : c[1:0];
      en = 1'h1;
      wt(6);
      `CHK("osc", (c[1:0] == 2'h3) ? 2'h0 : c[1:0], osc)
      `CHK("from reg", c[2], from_reg)
      `CHK("test mode", 2'h1, {normal, cmd})
      en = 1'h0;
      wt(6);
      `CHK("back", 4'h8, {normal, cmd, osc})
    end
    $display("test clock select done");
    seed = lfsr(seed);
    session(int'(seed % 16'h0003) + 1);
    session(0);
    report_and_stop();
  end
endmodule
